// *** rtl/pesb_pkg.sv ***
// Package for the pin event status bank: locations, field positions,
// mode codes, command carrier and summary layout.
// Assumes one clock domain and byte-wide scratch-pad locations.

package pesb_pkg;

   // ---------------------------------------------------------------
   // Sizes
   // ---------------------------------------------------------------
   localparam int PIN_COUNT   = 32;
   localparam int GROUP_PINS  = 16;
   localparam int LOC_COUNT   = 9;

   // ---------------------------------------------------------------
   // Scratch-pad locations
   // ---------------------------------------------------------------
   localparam logic [7:0] LOC_PROGRAM_SLOT_SELECT     = 8'h7F;
   localparam logic [7:0] LOC_MAIN_LOW_TRIGGER_FLAGS  = 8'h80;
   localparam logic [7:0] LOC_MAIN_HIGH_TRIGGER_FLAGS = 8'h81;
   localparam logic [7:0] LOC_AUX_LOW_TRIGGER_FLAGS   = 8'h82;
   localparam logic [7:0] LOC_AUX_HIGH_TRIGGER_FLAGS  = 8'h83;
   localparam logic [7:0] LOC_EVENT_MODE_VALUE        = 8'h84;
   localparam logic [7:0] LOC_JUMP_TARGET_SLOT        = 8'h85;
   localparam logic [7:0] LOC_IO_GROUP_SELECT         = 8'h86;
   localparam logic [7:0] LOC_MONITOR_SUMMARY_STATUS  = 8'h87;

   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int SLOT_ACTIVE_LSB = 0;
   localparam int SLOT_RW_LSB     = 4;
   localparam logic [7:0]  RST_BYTE  = 8'h00;
   localparam logic [3:0]  RST_MODE  = 4'h0;
   localparam logic [2:0]  RST_JUMP  = 3'h0;
   localparam logic [3:0]  RST_SLOT  = 4'h0;
   localparam logic [31:0] RST_PINS  = 32'h0000_0000;

   // ---------------------------------------------------------------
   // Mode codes (low three bits; bit 3 selects latched outputs)
   // ---------------------------------------------------------------
   localparam logic [2:0] MODE_OFF_CLEAR  = 3'h0;
   localparam logic [2:0] MODE_OFF_KEEP   = 3'h1;
   localparam logic [2:0] MODE_OUT_ONLY   = 3'h2;
   localparam logic [2:0] MODE_JUMP_ONLY  = 3'h3;
   localparam logic [2:0] MODE_OUT_JUMP   = 3'h4;
   localparam logic [2:0] MODE_CLR_INPUT  = 3'h5;
   localparam logic [2:0] MODE_CLR_OUTPUT = 3'h6;
   localparam logic [2:0] MODE_CLR_BOTH   = 3'h7;
   localparam int         MODE_LATCH_BIT  = 3;

   // ---------------------------------------------------------------
   // Commands from the interpreter
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_EVENT_MODE,
      CMD_EVENT_JUMP,
      CMD_WATCHED_INPUT,
      CMD_WATCHED_OUTPUT,
      CMD_EVENT_WAIT
   } pesb_cmd_e;

   // arg[4:0] pin (bit 4 = auxiliary group), arg[5] level; mode in arg[3:0]
   typedef struct packed {
      pesb_cmd_e  kind;
      logic [5:0] arg;
   } pesb_cmd_s;

   typedef struct packed {
      logic monitorActive;
      logic waitEvent;
      logic outputLatched;
      logic inputTriggered;
      logic latchMode;
      logic jumpEnabled;
      logic inputDefined;
      logic outputEnabled;
   } pesb_summary_s;

endpackage

// *** rtl/pesb_pin_match.sv ***
// Per-pin trigger match of watched inputs against their wanted level.
// Assumes pin levels are synchronous to the clock.

`timescale 1ns/1ps

module pesb_pin_match
   import pesb_pkg::*;
#(
   parameter int PINS = PIN_COUNT
) (
   // Pin levels and watch configuration
   input  wire logic [PINS-1:0] pinLevel,
   input  wire logic [PINS-1:0] watchEnable,
   input  wire logic [PINS-1:0] watchLevel,
   // Match result
   output      logic [PINS-1:0] hit,
   output      logic            anyHit
);

   // ---------------------------------------------------------------
   // Match per pin
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PINS; g++) begin : gMatch
         assign hit[g] = watchEnable[g] & (pinLevel[g] == watchLevel[g]);
      end
   endgenerate

   assign anyHit = |hit;

endmodule // pesb_pin_match

// *** rtl/pesb_read_mux.sv ***
// Read port of the status locations: decode and registered data.
// Assumes one read request per cycle; unmapped locations read as zero.

`timescale 1ns/1ps

module pesb_read_mux
   import pesb_pkg::*;
(
   // Clock and reset
   input  wire logic                      clock,
   input  wire logic                      nrst,
   // Location contents, index 0 is the lowest location
   input  wire logic [LOC_COUNT-1:0][7:0] bank,
   // Read request and answer
   input  wire logic                      rdEn,
   input  wire logic [7:0]                rdAddr,
   output      logic [7:0]                rdData,
   output      logic                      rdValid
);

   logic [7:0] index;
   logic       mapped;

   assign index  = rdAddr - LOC_PROGRAM_SLOT_SELECT;
   assign mapped = (rdAddr >= LOC_PROGRAM_SLOT_SELECT) &&
                   (rdAddr <= LOC_MONITOR_SUMMARY_STATUS);

   // ---------------------------------------------------------------
   // Registered answer
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rdData  <= RST_BYTE;
         rdValid <= 1'b0;
      end else begin
         rdValid <= rdEn;
         if (rdEn) begin
            rdData <= mapped ? bank[index[3:0]] : RST_BYTE;
         end
      end
   end

endmodule // pesb_read_mux

// *** rtl/pesb_status_bank.sv ***
// Pin event monitor with its scratch-pad status locations 127 to 135.
// Assumes the interpreter issues one command per cycle and pulses
// instrBoundary once between instructions.

`timescale 1ns/1ps

module pesb_status_bank
   import pesb_pkg::*;
(
   // Clock and reset
   input  wire logic                 clock,
   input  wire logic                 nrst,
   // Interpreter state
   input  wire logic                 instrBoundary,
   input  wire logic [3:0]           activeSlot,
   input  wire logic                 auxGroupSelected,
   // Interpreter commands
   input  wire pesb_cmd_s            cmd,
   // Scratch-pad write and read
   input  wire logic                 wrEn,
   input  wire logic [7:0]           wrAddr,
   input  wire logic [7:0]           wrData,
   input  wire logic                 rdEn,
   input  wire logic [7:0]           rdAddr,
   output      logic [7:0]           rdData,
   output      logic                 rdValid,
   // Pins
   input  wire logic [PIN_COUNT-1:0] pinIn,
   output      logic [PIN_COUNT-1:0] pinOut,
   output      logic [PIN_COUNT-1:0] pinOe,
   // Reactions
   output      logic                 jumpReq,
   output      logic [2:0]           jumpSlot,
   output      logic                 waitStall
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   logic [3:0]           modeValue;
   logic [2:0]           jumpTarget;
   logic [3:0]           rwSlot;
   logic [PIN_COUNT-1:0] inEnable;
   logic [PIN_COUNT-1:0] inLevel;
   logic [PIN_COUNT-1:0] outEnable;
   logic [PIN_COUNT-1:0] outState;
   logic [PIN_COUNT-1:0] trigFlags;
   logic                 waitEvent;
   logic                 outLatched;
   logic                 waitArmed;

   // ---------------------------------------------------------------
   // Decode of the mode value
   // ---------------------------------------------------------------
   logic [2:0] modeLow;
   logic       monitorActive;
   logic       outReact;
   logic       jumpReact;
   logic       latchMode;

   assign modeLow = modeValue[2:0];

   always_comb begin
      monitorActive = 1'b0;
      outReact      = 1'b0;
      jumpReact     = 1'b0;
      case (modeLow)
         MODE_OUT_ONLY: begin
            monitorActive = 1'b1;
            outReact      = 1'b1;
         end
         MODE_JUMP_ONLY: begin
            monitorActive = 1'b1;
            jumpReact     = 1'b1;
         end
         MODE_OUT_JUMP: begin
            monitorActive = 1'b1;
            outReact      = 1'b1;
            jumpReact     = 1'b1;
         end
         default: begin
            monitorActive = 1'b0;
         end
      endcase
   end

   assign latchMode = modeValue[MODE_LATCH_BIT];

   // ---------------------------------------------------------------
   // Decode of the command in flight
   // ---------------------------------------------------------------
   logic       modeCmd;
   logic [3:0] cmdMode;
   logic       cmdIsClear;
   logic       clearInputs;
   logic       clearOutputs;
   logic       inputCmd;
   logic       outputCmd;
   logic [4:0] cmdPin;
   logic       cmdLevel;

   assign modeCmd    = (cmd.kind == CMD_EVENT_MODE);
   assign cmdMode    = cmd.arg[3:0];
   assign cmdIsClear = (cmdMode[2:0] == MODE_CLR_INPUT) ||
                       (cmdMode[2:0] == MODE_CLR_OUTPUT) ||
                       (cmdMode[2:0] == MODE_CLR_BOTH);
   assign clearInputs  = modeCmd && ((cmdMode[2:0] == MODE_OFF_CLEAR) ||
                                     (cmdMode[2:0] == MODE_CLR_INPUT) ||
                                     (cmdMode[2:0] == MODE_CLR_BOTH));
   assign clearOutputs = modeCmd && ((cmdMode[2:0] == MODE_OFF_CLEAR) ||
                                     (cmdMode[2:0] == MODE_CLR_OUTPUT) ||
                                     (cmdMode[2:0] == MODE_CLR_BOTH));
   assign inputCmd  = (cmd.kind == CMD_WATCHED_INPUT);
   assign outputCmd = (cmd.kind == CMD_WATCHED_OUTPUT);
   assign cmdPin    = cmd.arg[4:0];
   assign cmdLevel  = cmd.arg[5];

   // ---------------------------------------------------------------
   // Input match at the instruction gap
   // ---------------------------------------------------------------
   logic [PIN_COUNT-1:0] hitVec;
   logic                 anyHit;
   logic                 sampleNow;
   logic                 jumpFire;
   logic                 outHold;

   pesb_pin_match #(
      .PINS        (PIN_COUNT)
   ) uMatch (
      .pinLevel    (pinIn),
      .watchEnable (inEnable),
      .watchLevel  (inLevel),
      .hit         (hitVec),
      .anyHit      (anyHit)
   );

   assign sampleNow = instrBoundary && monitorActive;
   assign jumpFire  = sampleNow && jumpReact && anyHit;
   assign outHold   = anyHit || (latchMode && outLatched);

   // ---------------------------------------------------------------
   // Mode value
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         modeValue <= RST_MODE;
      end else if (modeCmd && !cmdIsClear) begin
         modeValue <= cmdMode;
      end else if (jumpFire) begin
         if (modeLow == MODE_JUMP_ONLY) begin
            modeValue <= {modeValue[MODE_LATCH_BIT], MODE_OFF_KEEP};
         end else begin
            modeValue <= {modeValue[MODE_LATCH_BIT], MODE_OUT_ONLY};
         end
      end
   end

   // ---------------------------------------------------------------
   // Jump target and read/write slot
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         jumpTarget <= RST_JUMP;
      end else if (cmd.kind == CMD_EVENT_JUMP) begin
         jumpTarget <= cmd.arg[2:0];
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         rwSlot <= RST_SLOT;
      end else if (wrEn && (wrAddr == LOC_PROGRAM_SLOT_SELECT)) begin
         rwSlot <= wrData[SLOT_RW_LSB +: 4];
      end
   end

   // ---------------------------------------------------------------
   // Watched input configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         inEnable <= RST_PINS;
         inLevel  <= RST_PINS;
      end else if (clearInputs) begin
         inEnable <= RST_PINS;
         inLevel  <= RST_PINS;
      end else if (inputCmd) begin
         inEnable[cmdPin] <= 1'b1;
         inLevel[cmdPin]  <= cmdLevel;
      end
   end

   // ---------------------------------------------------------------
   // Watched output configuration
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         outEnable <= RST_PINS;
         outState  <= RST_PINS;
      end else if (clearOutputs) begin
         outEnable <= RST_PINS;
         outState  <= RST_PINS;
      end else if (outputCmd) begin
         outEnable[cmdPin] <= 1'b1;
         outState[cmdPin]  <= cmdLevel;
      end
   end

   // ---------------------------------------------------------------
   // Output pin drive, one flop pair per pin
   // ---------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < PIN_COUNT; g++) begin : gDrive
         always_ff @(posedge clock or negedge nrst) begin
            if (!nrst) begin
               pinOut[g] <= 1'b0;
               pinOe[g]  <= 1'b0;
            end else if (outputCmd && (cmdPin == 5'(g))) begin
               pinOe[g]  <= 1'b1;
               pinOut[g] <= ~cmdLevel;
            end else if (sampleNow && outReact && outEnable[g]) begin
               pinOut[g] <= outHold ? outState[g] : ~outState[g];
            end
         end
      end
   endgenerate

   // ---------------------------------------------------------------
   // Trigger flags
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         trigFlags <= RST_PINS;
      end else if (sampleNow) begin
         if (latchMode) begin
            trigFlags <= (clearInputs ? RST_PINS : trigFlags) | hitVec;
         end else begin
            trigFlags <= hitVec;
         end
      end else if (clearInputs) begin
         trigFlags <= RST_PINS;
      end
   end

   // ---------------------------------------------------------------
   // Latch state and wait event
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         outLatched <= 1'b0;
      end else if (sampleNow && outReact && latchMode && anyHit) begin
         outLatched <= 1'b1;
      end else if (modeCmd && !cmdIsClear) begin
         outLatched <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         waitEvent <= 1'b0;
      end else if (sampleNow && outReact && anyHit) begin
         waitEvent <= 1'b1;
      end else if (modeCmd) begin
         waitEvent <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         waitArmed <= 1'b0;
      end else if (cmd.kind == CMD_EVENT_WAIT) begin
         waitArmed <= 1'b1;
      end else if ((sampleNow && outReact && anyHit) || modeCmd) begin
         waitArmed <= 1'b0;
      end
   end

   assign waitStall = waitArmed;

   // ---------------------------------------------------------------
   // Jump request
   // ---------------------------------------------------------------
   always_ff @(posedge clock or negedge nrst) begin
      if (!nrst) begin
         jumpReq  <= 1'b0;
         jumpSlot <= RST_JUMP;
      end else begin
         jumpReq <= jumpFire;
         if (jumpFire) begin
            jumpSlot <= jumpTarget;
         end
      end
   end

   // ---------------------------------------------------------------
   // Status locations
   // ---------------------------------------------------------------
   pesb_summary_s                 summary;
   logic [LOC_COUNT-1:0][7:0]     bank;

   always_comb begin
      summary.outputEnabled  = outReact;
      summary.inputDefined   = |inEnable;
      summary.jumpEnabled    = jumpReact;
      summary.latchMode      = latchMode;
      summary.inputTriggered = |trigFlags;
      summary.outputLatched  = outLatched;
      summary.waitEvent      = waitEvent;
      summary.monitorActive  = monitorActive;
   end

   assign bank[0] = {rwSlot, activeSlot};
   assign bank[1] = trigFlags[7:0];
   assign bank[2] = trigFlags[15:8];
   assign bank[3] = trigFlags[GROUP_PINS +: 8];
   assign bank[4] = trigFlags[GROUP_PINS+8 +: 8];
   assign bank[5] = {4'h0, modeValue};
   assign bank[6] = {5'h00, jumpTarget};
   assign bank[7] = {7'h00, auxGroupSelected};
   assign bank[8] = summary;

   pesb_read_mux uRead (
      .clock   (clock),
      .nrst    (nrst),
      .bank    (bank),
      .rdEn    (rdEn),
      .rdAddr  (rdAddr),
      .rdData  (rdData),
      .rdValid (rdValid)
   );

endmodule // pesb_status_bank

// *** dv/pesb_checker.sv ***
// Concurrent checks on the top ports of the pin event status bank.
// Assumes one clock domain; bound onto pesb_status_bank below.
`timescale 1ns/1ps
module pesb_checker
   import pesb_pkg::*;
(
   // Clock and reset
   input wire logic                 clock,
   input wire logic                 nrst,
   // Inputs
   input wire logic                 instrBoundary,
   input wire logic [3:0]           activeSlot,
   input wire logic                 auxGroupSelected,
   input wire pesb_cmd_s            cmd,
   input wire logic                 rdEn,
   input wire logic [7:0]           rdAddr,
   // Outputs
   input wire logic [7:0]           rdData,
   input wire logic                 rdValid,
   input wire logic [PIN_COUNT-1:0] pinOut,
   input wire logic [PIN_COUNT-1:0] pinOe,
   input wire logic                 jumpReq,
   input wire logic                 waitStall
);
   // ----------------------------------------
   // Properties
   // ----------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   AST_RD_SLOT: assert property (rdEn && rdAddr == 8'h7F |=>
      rdValid && rdData[3:0] == $past(activeSlot)) else $error("slot read wrong");
   AST_RD_GROUP: assert property (rdEn && rdAddr == 8'h86 |=>
      rdValid && rdData[0] == $past(auxGroupSelected)) else $error("group read wrong");
   AST_RD_MODE: assert property (rdEn && rdAddr == 8'h84 |=>
      rdData[7:4] == 4'h0 && rdData[2:0] < 3'h5) else $error("mode read wrong");
   AST_SUM_ACTIVE: assert property (rdEn && rdAddr == 8'h87 |=>
      rdData[7] == (rdData[0] | rdData[2])) else $error("active bit wrong");
   AST_SUM_TRIG: assert property (rdEn && rdAddr == 8'h87 |=>
      !rdData[4] || rdData[1]) else $error("trigger without input");
   AST_JUMP_ONCE: assert property (jumpReq |=> !jumpReq)
      else $error("jump repeated");
   AST_JUMP_GAP: assert property ($rose(jumpReq) |-> $past(instrBoundary))
      else $error("jump outside gap");
   AST_PIN_HOLD: assert property (!instrBoundary && cmd.kind != CMD_WATCHED_OUTPUT
      |=> $stable(pinOut)) else $error("pin moved outside gap");
   AST_OE_HOLD: assert property (cmd.kind != CMD_WATCHED_OUTPUT |=> $stable(pinOe))
      else $error("pin enable moved");
   AST_WAIT_HOLD: assert property (waitStall && !instrBoundary
      && cmd.kind != CMD_EVENT_MODE |=> waitStall) else $error("wait dropped");
   AST_RESET: assert property (disable iff (1'b0) !nrst |=>
      !rdValid && !jumpReq && !waitStall && pinOe == '0) else $error("reset value");
   COV_JUMP: cover property (jumpReq);
   COV_WAIT: cover property ($rose(waitStall));
   COV_SUM: cover property (rdEn && rdAddr == 8'h87);
   COV_GAP: cover property (instrBoundary && pinOe != '0);
endmodule // pesb_checker

bind pesb_status_bank pesb_checker u_chk (.clock(clock), .nrst(nrst),
   .instrBoundary(instrBoundary), .activeSlot(activeSlot),
   .auxGroupSelected(auxGroupSelected), .cmd(cmd), .rdEn(rdEn), .rdAddr(rdAddr),
   .rdData(rdData), .rdValid(rdValid), .pinOut(pinOut), .pinOe(pinOe),
   .jumpReq(jumpReq), .waitStall(waitStall));

// *** dv/test_pesb_status_bank.sv ***
// Self-checking bench for the pin event status bank.
// Assumes the checker is bound; inputs change at falling edges.
`timescale 1ns/1ps
module test_pesb_status_bank
   import pesb_pkg::*;
;
   logic                 clock = 1'b0;
   logic                 nrst = 1'b0;
   logic                 instrBoundary = 1'b0;
   logic [3:0]           activeSlot = 4'h0;
   logic                 auxGroupSelected = 1'b0;
   pesb_cmd_s            cmd = '{CMD_NONE, 6'h00};
   logic                 wrEn = 1'b0;
   logic [7:0]           wrAddr = 8'h00;
   logic [7:0]           wrData = 8'h00;
   logic                 rdEn = 1'b0;
   logic [7:0]           rdAddr = 8'h00;
   logic [PIN_COUNT-1:0] pinIn = '0;
   logic [7:0]           rdData;
   logic                 rdValid;
   logic [PIN_COUNT-1:0] pinOut;
   logic [PIN_COUNT-1:0] pinOe;
   logic                 jumpReq;
   logic [2:0]           jumpSlot;
   logic                 waitStall;
   int                   fail_count = 0;
   int                   tests_run = 0;
   int                   seed = 9444;
   int                   p, q, s, n, wt;
   logic [3:0]           st;
   logic [7:0]           fa, fb;

   always #5 clock = ~clock;

   pesb_status_bank dut (.clock(clock), .nrst(nrst), .instrBoundary(instrBoundary),
      .activeSlot(activeSlot), .auxGroupSelected(auxGroupSelected), .cmd(cmd),
      .wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .rdEn(rdEn), .rdAddr(rdAddr),
      .rdData(rdData), .rdValid(rdValid), .pinIn(pinIn), .pinOut(pinOut),
      .pinOe(pinOe), .jumpReq(jumpReq), .jumpSlot(jumpSlot), .waitStall(waitStall));

   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic rdc(input logic [7:0] a, input logic [7:0] e);
      @(negedge clock);
      rdEn = 1'b1;
      rdAddr = a;
      @(negedge clock);
      rdEn = 1'b0;
      chk("rdValid", 32'h1, rdValid);
      chk($sformatf("loc %h", a), e, rdData);
   endtask
   task automatic cm(input pesb_cmd_e k, input logic [5:0] a);
      @(negedge clock);
      cmd = '{k, a};
      @(negedge clock);
      cmd = '{CMD_NONE, 6'h00};
   endtask
   task automatic bd();
      @(negedge clock);
      instrBoundary = 1'b1;
      @(negedge clock);
      instrBoundary = 1'b0;
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", tests_run, fail_count);
      if (fail_count == 0 && tests_run > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   function automatic logic [7:0] es(logic [3:0] m, logic d, logic t, logic l, logic w);
      logic o;
      logic j;
      o = (m[2:0] == 3'h2) || (m[2:0] == 3'h4);
      j = (m[2:0] == 3'h3) || (m[2:0] == 3'h4);
      return {o | j, w, l, t, m[3], j, d, o};
   endfunction

   // ----------------------------------------
   // Sequence
   // ----------------------------------------
   initial begin
      repeat (4) @(negedge clock);
      nrst = 1'b1;
      activeSlot = 4'($random(seed));
      rdc(8'h7F, {4'h0, activeSlot});
      for (n = 1; n < 9; n++) rdc(8'h7F + 8'(n), 8'h00);
      rdc(8'h7E, 8'h00);
      fa = 8'($random(seed));
      if (fa >= 8'h7F && fa <= 8'h88) fa = 8'h00;
      rdc(fa, 8'h00);
      fb = 8'($random(seed));
      @(negedge clock);
      wrEn = 1'b1;
      wrAddr = 8'h7F;
      wrData = fb;
      @(negedge clock);
      wrAddr = 8'h85;
      @(negedge clock);
      wrEn = 1'b0;
      rdc(8'h7F, {fb[7:4], activeSlot});
      rdc(8'h85, 8'h00);
      for (n = 0; n < 2; n++) begin
         auxGroupSelected = n[0];
         rdc(8'h86, {7'h00, n[0]});
      end
      $display("end of reset and slot test");
      st = 4'h0;
      for (n = 0; n < 16; n++) begin
         cm(CMD_EVENT_MODE, 6'(n));
         if (n % 8 < 5) st = 4'(n);
         rdc(8'h84, {4'h0, st});
         rdc(8'h87, es(st, 1'b0, 1'b0, 1'b0, 1'b0));
      end
      $display("end of mode table test");
      p = {$random(seed)} % 32;
      q = (p + 1 + {$random(seed)} % 31) % 32;
      fa = 8'h80 + 8'(p / 8);
      fb = 8'h01 << (p % 8);
      pinIn = $random(seed);
      pinIn[p] = 1'b1;
      cm(CMD_WATCHED_INPUT, {1'b0, 5'(p)});
      cm(CMD_WATCHED_OUTPUT, {1'b1, 5'(q)});
      chk("pinOe", 32'h1, pinOe[q]);
      chk("pinOut", 32'h0, pinOut[q]);
      cm(CMD_EVENT_MODE, 6'h02);
      cm(CMD_EVENT_WAIT, 6'h00);
      chk("waitStall", 32'h1, waitStall);
      pinIn[p] = 1'b0;
      bd();
      chk("waitStall", 32'h0, waitStall);
      chk("pinOut", 32'h1, pinOut[q]);
      rdc(fa, fb);
      rdc(8'h87, es(4'h2, 1'b1, 1'b1, 1'b0, 1'b1));
      pinIn[p] = 1'b1;
      bd();
      chk("pinOut", 32'h0, pinOut[q]);
      rdc(fa, 8'h00);
      rdc(8'h87, es(4'h2, 1'b1, 1'b0, 1'b0, 1'b1));
      cm(CMD_EVENT_MODE, 6'h01);
      rdc(8'h87, es(4'h1, 1'b1, 1'b0, 1'b0, 1'b0));
      chk("pinOe", 32'h1, pinOe[q]);
      pinIn[p] = 1'b0;
      bd();
      rdc(fa, 8'h00);
      chk("pinOut", 32'h0, pinOut[q]);
      $display("end of output reaction test");
      s = {$random(seed)} % 8;
      cm(CMD_EVENT_JUMP, 6'(s));
      rdc(8'h85, 8'(s));
      for (n = 0; n < 2; n++) begin
         cm(CMD_EVENT_MODE, 6'(3 + n));
         bd();
         for (wt = 0; wt < 4 && jumpReq !== 1'b1; wt++) @(negedge clock);
         if (wt == 4) begin
            fail_count++;
            tally_and_finish();
         end
         chk("jumpSlot", s, jumpSlot);
         rdc(8'h84, 8'(1 + n));
      end
      $display("end of jump test");
      cm(CMD_EVENT_MODE, 6'h0A);
      bd();
      rdc(8'h87, es(4'hA, 1'b1, 1'b1, 1'b1, 1'b1));
      pinIn[p] = 1'b1;
      bd();
      chk("pinOut", 32'h1, pinOut[q]);
      rdc(fa, fb);
      cm(CMD_EVENT_MODE, 6'h06);
      rdc(8'h84, 8'h0A);
      chk("pinOut", 32'h1, pinOut[q]);
      cm(CMD_EVENT_MODE, 6'h00);
      rdc(8'h87, 8'h00);
      rdc(fa, 8'h00);
      $display("end of latch test");
      tally_and_finish();
   end
endmodule // test_pesb_status_bank
